// ===== hdl/vtm_addr_calc.sv
// vtm_addr_calc: turns a vector number and table select into an entry address
module vtm_addr_calc (
   input  wire logic [6:0]  i_vec_num,
   input  wire logic        i_alt_sel,
   output logic      [23:0] o_addr
);
   wire logic [23:0] base_addr;
   wire logic [23:0] vec_ofs;

   // entries are two address units apart from the trap base
   assign vec_ofs   = {16'h0000, i_vec_num, 1'b0};
   assign base_addr = vtm_pkg::TRAP_BASE + vec_ofs;
   assign o_addr    = i_alt_sel ? base_addr + vtm_pkg::ALT_OFFSET
                                : base_addr;
endmodule

// ===== hdl/vtm_pkg.sv
// vtm_pkg: constants shared by the vector table map design files
package vtm_pkg;
   localparam int unsigned ADDR_W       = 24;
   localparam int unsigned VEC_W        = 7;
   localparam int unsigned IRQ_W        = 7;
   localparam int unsigned NUM_IRQ      = 72;
   localparam int unsigned NUM_TRAP     = 8;
   localparam int unsigned NUM_PRI_LVL  = 8;
   localparam logic [2:0]  PRI_W        = 3'h3;
   localparam logic [23:0] RESET_ADDR   = 24'h000000;
   localparam logic [23:0] TRAP_BASE    = 24'h000004;
   localparam logic [23:0] IRQ_BASE     = 24'h000014;
   localparam logic [23:0] ALT_OFFSET   = 24'h000100;
   localparam logic [6:0]  IRQ_VEC_OFS  = 7'h08;
   localparam logic [6:0]  LAST_IRQ     = 7'h47;
   localparam logic [6:0]  LAST_VEC     = 7'h4f;
   // trap numbers
   localparam logic [2:0]  TRAP_OSC     = 3'h1;
   localparam logic [2:0]  TRAP_ADDR    = 3'h2;
   localparam logic [2:0]  TRAP_STACK   = 3'h3;
   localparam logic [2:0]  TRAP_MATH    = 3'h4;
   localparam logic [2:0]  TRAP_DMA     = 3'h5;
   localparam logic [7:0]  TRAP_IMPL    = 8'h3e;
   // reserved request slots: 15 18 45 57 58 62 63 64 67
   localparam logic [71:0] IRQ_RESERVED = 72'h09_c600_2000_0004_8000;
   // request numbers of each source group
   localparam logic [6:0] IRQ_EXT  [5] = '{7'h00, 7'h14, 7'h1d, 7'h35, 7'h36};
   localparam logic [6:0] IRQ_DMA  [8] = '{7'h04, 7'h0e, 7'h18, 7'h24, 7'h2e, 7'h3d, 7'h44, 7'h45};
   localparam logic [6:0] IRQ_TMR  [9] = '{7'h03, 7'h07, 7'h08, 7'h1b, 7'h1c, 7'h2f, 7'h30, 7'h33, 7'h34};
   localparam logic [6:0] IRQ_IC   [8] = '{7'h01, 7'h05, 7'h25, 7'h26, 7'h27, 7'h28, 7'h16, 7'h17};
   localparam logic [6:0] IRQ_OC   [8] = '{7'h02, 7'h06, 7'h19, 7'h1a, 7'h29, 7'h2a, 7'h2b, 7'h2c};
   localparam logic [6:0] IRQ_SER  [6] = '{7'h0b, 7'h0c, 7'h41, 7'h1e, 7'h1f, 7'h42};
   localparam logic [6:0] IRQ_TWI  [4] = '{7'h10, 7'h11, 7'h31, 7'h32};
   localparam logic [6:0] IRQ_CAN  [6] = '{7'h22, 7'h23, 7'h46, 7'h37, 7'h38, 7'h47};
   localparam logic [6:0] IRQ_SYNC [4] = '{7'h09, 7'h0a, 7'h20, 7'h21};
   localparam logic [6:0] IRQ_MISC [5] = '{7'h0d, 7'h15, 7'h13, 7'h3b, 7'h3c};
endpackage

// ===== hdl/vtm_req_map.sv
// vtm_req_map: routes named peripheral events onto their request slots
module vtm_req_map (
   input  wire logic [4:0]  i_ext_irq,
   input  wire logic [7:0]  i_dma_done,
   input  wire logic [8:0]  i_timer_period,
   input  wire logic [7:0]  i_capture,
   input  wire logic [7:0]  i_compare,
   input  wire logic [5:0]  i_serial,
   input  wire logic [3:0]  i_twowire,
   input  wire logic [5:0]  i_can,
   input  wire logic [3:0]  i_sync_serial,
   input  wire logic [4:0]  i_misc,
   output logic      [71:0] o_req
);
   always_comb begin
      o_req = '0;
      for (int i = 0; i < 5; i++) begin
         o_req[vtm_pkg::IRQ_EXT[i]]  = i_ext_irq[i];
         o_req[vtm_pkg::IRQ_MISC[i]] = i_misc[i];
      end
      for (int i = 0; i < 8; i++) begin
         o_req[vtm_pkg::IRQ_DMA[i]] = i_dma_done[i];
         o_req[vtm_pkg::IRQ_IC[i]]  = i_capture[i];
         o_req[vtm_pkg::IRQ_OC[i]]  = i_compare[i];
      end
      for (int i = 0; i < 9; i++) begin
         o_req[vtm_pkg::IRQ_TMR[i]] = i_timer_period[i];
      end
      for (int i = 0; i < 6; i++) begin
         o_req[vtm_pkg::IRQ_SER[i]] = i_serial[i];
         o_req[vtm_pkg::IRQ_CAN[i]] = i_can[i];
      end
      for (int i = 0; i < 4; i++) begin
         o_req[vtm_pkg::IRQ_TWI[i]]  = i_twowire[i];
         o_req[vtm_pkg::IRQ_SYNC[i]] = i_sync_serial[i];
      end
   end
endmodule

// ===== hdl/vtm_vector_table_map.sv
// vtm_vector_table_map: picks the winning trap or request and presents its vector
// ==========================================================================
module vtm_vector_table_map (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_alt_table_select,
   input  wire logic [7:0]  i_trap,
   input  wire logic [4:0]  i_ext_irq,
   input  wire logic [7:0]  i_dma_done,
   input  wire logic [8:0]  i_timer_period,
   input  wire logic [7:0]  i_capture,
   input  wire logic [7:0]  i_compare,
   input  wire logic [5:0]  i_serial,
   input  wire logic [3:0]  i_twowire,
   input  wire logic [5:0]  i_can,
   input  wire logic [3:0]  i_sync_serial,
   input  wire logic [4:0]  i_misc,
   input  wire logic [71:0] i_irq_enable,
   input  wire logic [215:0] i_irq_priority,
   input  wire logic [2:0]  i_cpu_level,
   input  wire logic        i_vec_ack,
   output logic             o_vec_valid,
   output logic             o_vec_is_trap,
   output logic      [6:0]  o_vec_num,
   output logic      [23:0] o_vec_addr,
   output logic      [23:0] o_fetch_addr,
   output logic             o_fetch_from_reset
);
   // ========================================================================
   // source mapping
   wire logic [71:0] raw_req;
   wire logic [71:0] live_req;

   vtm_req_map u_req_map (
      .i_ext_irq      (i_ext_irq),
      .i_dma_done     (i_dma_done),
      .i_timer_period (i_timer_period),
      .i_capture      (i_capture),
      .i_compare      (i_compare),
      .i_serial       (i_serial),
      .i_twowire      (i_twowire),
      .i_can          (i_can),
      .i_sync_serial  (i_sync_serial),
      .i_misc         (i_misc),
      .o_req          (raw_req)
   );

   // reserved slots never request, whatever drives them
   assign live_req = raw_req & i_irq_enable & ~vtm_pkg::IRQ_RESERVED;

   // ========================================================================
   // arbitration: traps first, then highest level, then lowest number
   wire logic [7:0] live_trap;
   wire logic       trap_hit;
   logic      [2:0] trap_win;
   logic      [6:0] irq_win;
   logic      [2:0] irq_win_lvl;
   logic            irq_hit;

   assign live_trap = i_trap & vtm_pkg::TRAP_IMPL;
   assign trap_hit  = |live_trap;

   always_comb begin
      trap_win = 3'h0;
      for (int t = vtm_pkg::NUM_TRAP - 1; t >= 0; t--) begin
         if (live_trap[t]) begin
            trap_win = 3'(t);
         end
      end
   end

   always_comb begin
      logic [2:0] lvl;
      irq_win     = 7'h00;
      irq_win_lvl = 3'h0;
      irq_hit     = 1'b0;
      lvl         = 3'h0;
      // scanning downward with >= keeps the lowest number on a tie
      for (int n = vtm_pkg::NUM_IRQ - 1; n >= 0; n--) begin
         lvl = i_irq_priority[n*3 +: 3];
         if (live_req[n] && lvl > i_cpu_level && (!irq_hit || lvl >= irq_win_lvl)) begin
            irq_win     = 7'(n);
            irq_win_lvl = lvl;
            irq_hit     = 1'b1;
         end
      end
   end

   // ========================================================================
   // vector number and address, presented in the choosing cycle
   wire logic [6:0]  win_vec;
   wire logic        any_hit;
   wire logic [23:0] win_addr;

   assign any_hit = trap_hit | irq_hit;
   assign win_vec = trap_hit ? {4'h0, trap_win}
                             : irq_win + vtm_pkg::IRQ_VEC_OFS;

   vtm_addr_calc u_addr_calc (
      .i_vec_num (win_vec),
      .i_alt_sel (i_alt_table_select),
      .o_addr    (win_addr)
   );

   // combinational so the core sees the entry in the choosing cycle
   assign o_vec_valid   = i_rst_n & any_hit;
   assign o_vec_is_trap = i_rst_n & trap_hit;
   assign o_vec_num     = win_vec;
   assign o_vec_addr    = win_addr;

   // ========================================================================
   // reset entry: a plain clear, not an exception
   logic        from_reset_ff;
   logic [23:0] fetch_ff;
   wire  logic  vec_taken;
   wire  logic [23:0] nxt_fetch;

   assign vec_taken = o_vec_valid & i_vec_ack;
   assign nxt_fetch = vec_taken ? win_addr : fetch_ff;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         fetch_ff      <= vtm_pkg::RESET_ADDR;
         from_reset_ff <= 1'b1;
      end else begin
         fetch_ff      <= nxt_fetch;
         from_reset_ff <= from_reset_ff & ~vec_taken;
      end
   end

   assign o_fetch_addr       = fetch_ff;
   assign o_fetch_from_reset = from_reset_ff;

   // ========================================================================
   // checks
   sequence s_reset_pulse;
      !i_rst_n;
   endsequence

   sequence s_reset_entry;
      (o_fetch_addr == vtm_pkg::RESET_ADDR) && o_fetch_from_reset;
   endsequence

   a_reset_entry_zero: assert property (
      @(posedge i_clk) s_reset_pulse |=> s_reset_entry)
      else $error("reset did not force fetch address to zero");

   a_reset_no_vector: assert property (
      @(posedge i_clk) !i_rst_n |-> !o_vec_valid)
      else $error("vector request raised during reset");

   a_reset_addr_hold: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (o_fetch_from_reset && !vec_taken) |=> (o_fetch_addr == 24'h000000))
      else $error("fetch address left zero without a vector");

   a_trap_addr_map: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (trap_hit && !i_alt_table_select) |->
         (o_vec_addr == 24'h000004 + {20'h00000, o_vec_num[2:0], 1'b0}) && o_vec_num < 7'h08)
      else $error("trap entry address wrong");

   a_irq_addr_map: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (o_vec_valid && !trap_hit && !i_alt_table_select) |->
         (o_vec_addr == 24'h000014 + {16'h0000, irq_win, 1'b0}) && (o_vec_num == irq_win + 7'h08))
      else $error("request entry address wrong");

   a_alt_table_ofs: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (o_vec_valid && i_alt_table_select) |->
         (o_vec_addr == 24'h000104 + {16'h0000, o_vec_num, 1'b0}))
      else $error("alternate entry not 0x100 above primary");

   a_reserved_quiet: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (o_vec_valid && !trap_hit) |-> !vtm_pkg::IRQ_RESERVED[irq_win] && o_vec_num <= 7'h4f)
      else $error("reserved request slot won");

   a_trap_reserved: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_trap != 8'h00 && (i_trap & 8'h3e) == 8'h00 && !irq_hit) |-> !o_vec_valid)
      else $error("reserved trap produced a vector");

   a_tie_low_wins: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (o_vec_valid && trap_hit) |-> (live_trap & ((8'h01 << trap_win) - 8'h01)) == 8'h00)
      else $error("lower trap lost arbitration");

   a_vector_taken: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      vec_taken |=> (o_fetch_addr == $past(o_vec_addr)) && !o_fetch_from_reset)
      else $error("taken vector not loaded as fetch address");

   // ========================================================================
   // helpers for the checks below; nothing on the output path reads them
   wire logic [71:0] lvl_ok;
   logic             chk_any_elig;
   logic             chk_better;

   for (genvar g = 0; g < vtm_pkg::NUM_IRQ; g++) begin : g_lvl
      assign lvl_ok[g] = i_irq_priority[g*3 +: 3] > i_cpu_level;
   end

   // a second scan, run upward, so a slip in the arbiter's tie rule shows up
   always_comb begin
      chk_any_elig = 1'b0;
      chk_better   = 1'b0;
      for (int n = 0; n < int'(vtm_pkg::NUM_IRQ); n++) begin
         if (live_req[n] && lvl_ok[n]) begin
            chk_any_elig = 1'b1;
            if (i_irq_priority[n*3 +: 3] > irq_win_lvl) begin
               chk_better = 1'b1;
            end
            if (i_irq_priority[n*3 +: 3] == irq_win_lvl && n < int'(irq_win)) begin
               chk_better = 1'b1;
            end
         end
      end
   end

   sequence s_trap_present;
      o_vec_valid && o_vec_is_trap;
   endsequence

   sequence s_irq_present;
      o_vec_valid && !o_vec_is_trap;
   endsequence

   sequence s_inputs_still;
      $past(i_rst_n) && $stable(i_trap) && $stable(raw_req) && $stable(i_irq_enable) &&
      $stable(i_irq_priority) && $stable(i_cpu_level) && $stable(i_alt_table_select);
   endsequence

   // ========================================================================
   // reset entry and fetch address checks
   // reset is a plain clear: the first fetch after release is the zero address
   a_release_at_zero: assert property (
      @(posedge i_clk) $rose(i_rst_n) |-> s_reset_entry)
      else $error("fetch address not zero when reset released");

   a_entry_flag_hold: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (o_fetch_from_reset && !vec_taken) |=> o_fetch_from_reset)
      else $error("reset entry flag dropped without a taken vector");

   a_entry_flag_once: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      !o_fetch_from_reset |=> !o_fetch_from_reset)
      else $error("reset entry flag rose outside reset");

   a_fetch_holds: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      !vec_taken |=> $stable(o_fetch_addr))
      else $error("fetch address moved without a taken vector");

   a_ack_alone_void: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_vec_ack && !o_vec_valid) |=> $stable(o_fetch_addr) && $stable(o_fetch_from_reset))
      else $error("acknowledge with nothing presented changed the fetch state");

   // ========================================================================
   // trap checks
   a_trap_beats_irq: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      ((i_trap & vtm_pkg::TRAP_IMPL) != 8'h00) |-> s_trap_present)
      else $error("implemented trap did not take precedence");

   a_trap_num_legal: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      s_trap_present |-> (o_vec_num >= {4'h0, vtm_pkg::TRAP_OSC}) && (o_vec_num <= {4'h0, vtm_pkg::TRAP_DMA}))
      else $error("trap vector outside the implemented traps");

   a_osc_trap_first: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      i_trap[vtm_pkg::TRAP_OSC] |-> o_vec_is_trap && (o_vec_num == {4'h0, vtm_pkg::TRAP_OSC}))
      else $error("oscillator trap did not present its vector");

   a_dma_trap_vec: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      ((i_trap & vtm_pkg::TRAP_IMPL) == (8'h01 << vtm_pkg::TRAP_DMA)) |->
         o_vec_is_trap && (o_vec_num == {4'h0, vtm_pkg::TRAP_DMA}))
      else $error("dma trap did not present its vector");

   a_alt_trap_ofs: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (o_vec_valid && o_vec_is_trap && i_alt_table_select) |->
         (o_vec_addr == vtm_pkg::ALT_OFFSET + vtm_pkg::TRAP_BASE + {16'h0000, o_vec_num, 1'b0}))
      else $error("alternate trap entry misplaced");

   // ========================================================================
   // address checks
   a_addr_in_table: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      o_vec_valid |-> (o_vec_addr[0] == 1'b0) && (o_vec_addr[23:9] == 15'h0) && (o_vec_addr[7:0] >= 8'h04))
      else $error("entry address outside both tables");

   a_table_half: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      o_vec_valid |-> (o_vec_addr[8] == i_alt_table_select))
      else $error("entry address in the wrong table");

   // the presentation is a pure function of the inputs, so it may not drift while they stand
   a_vec_stands: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      s_inputs_still |-> $stable(o_vec_valid) && $stable(o_vec_addr))
      else $error("presented vector changed while its inputs stood");

   // ========================================================================
   // arbitration checks
   a_irq_best_wins: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      s_irq_present |-> !chk_better)
      else $error("a better request lost arbitration");

   a_irq_not_lost: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (!trap_hit && chk_any_elig) |-> s_irq_present)
      else $error("eligible request not presented");

   a_irq_level_gate: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      s_irq_present |-> lvl_ok[irq_win] && i_irq_enable[irq_win] && raw_req[irq_win])
      else $error("request won without level, enable or request");

   a_irq_top_limit: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      s_irq_present |-> (irq_win <= vtm_pkg::LAST_IRQ) && (o_vec_num <= vtm_pkg::LAST_VEC))
      else $error("request beyond the highest implemented source");
endmodule

// ===== tb/tb_top.sv
// tb_top: self-checking bench for the vector table map
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // stimulus and observed signals
   logic         i_clk = 1'b0;
   logic         i_rst_n = 1'b0;
   logic         alt = 1'b0;
   logic [7:0]   trap = 8'h00;
   logic [62:0]  src = '0;
   logic [71:0]  en = '1;
   logic [215:0] pri = {72{3'h1}};
   logic [2:0]   lvl = 3'h0;
   logic         go = 1'b0;
   logic         stray = 1'b0;
   logic [3:0]   wt = 4'h0;
   logic         ack, valid, is_trap, from_rst;
   logic [6:0]   num;
   logic [23:0]  vaddr, faddr;
   int           error_cnt = 0;
   int           tests_run = 0;
   // request number of each source bit, in port order
   byte unsigned rq [63] = '{0, 20, 29, 53, 54,
      4, 14, 24, 36, 46, 61, 68, 69,
      3, 7, 8, 27, 28, 47, 48, 51, 52,
      1, 5, 37, 38, 39, 40, 22, 23, 2, 6, 25, 26, 41, 42, 43, 44,
      11, 12, 65, 30, 31, 66, 16, 17, 49, 50,
      34, 35, 70, 55, 56, 71, 9, 10, 32, 33,
      13, 21, 19, 59, 60};
   initial forever #2.5 i_clk = ~i_clk;
   vtm_vector_table_map u_vtm_vector_table_map (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_alt_table_select(alt),
      .i_trap(trap), .i_ext_irq(src[4:0]), .i_dma_done(src[12:5]), .i_timer_period(src[21:13]),
      .i_capture(src[29:22]), .i_compare(src[37:30]), .i_serial(src[43:38]), .i_twowire(src[47:44]),
      .i_can(src[53:48]), .i_sync_serial(src[57:54]), .i_misc(src[62:58]), .i_irq_enable(en),
      .i_irq_priority(pri), .i_cpu_level(lvl), .i_vec_ack(ack), .o_vec_valid(valid), .o_vec_is_trap(is_trap),
      .o_vec_num(num), .o_vec_addr(vaddr), .o_fetch_addr(faddr), .o_fetch_from_reset(from_rst));
   vtm_core_model u_vtm_core_model (.i_clk(i_clk), .i_go(go), .i_stray(stray), .i_wait(wt),
      .i_vec_valid(valid), .o_vec_ack(ack));
   // ====================
   // helpers
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [23:0] ea(input int v, input logic a);
      return 24'h000004 + 24'(2 * v) + (a ? 24'h000100 : 24'h000000);
   endfunction
   task automatic see(input logic v, input logic t, input int n, input logic a);
      #1;
      chk(24'(valid), 24'(v));
      if (v) begin
         chk(24'(is_trap), 24'(t));
         chk(24'(num), 24'(n));
         chk(vaddr, ea(n, a));
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ====================
   // scenarios
   task automatic t_reset;
      @(negedge i_clk);
      i_rst_n = 1'b0;
      trap = 8'h02;
      src = 63'h1;
      repeat (4) begin
         see(1'b0, 1'b0, 0, 1'b0);
         @(negedge i_clk);
      end
      i_rst_n = 1'b1;
      trap = 8'h00;
      src = '0;
      #1;
      chk(faddr, 24'h000000);
      chk(24'(from_rst), 24'h1);
      $display("reset test done");
   endtask
   task automatic t_traps;
      for (int t = 0; t < 16; t++) begin
         @(negedge i_clk);
         trap = 8'h01 << t[2:0];
         alt = t[3];
         see(t % 8 inside {[1:5]}, 1'b1, t % 8, alt);
      end
      @(negedge i_clk);
      trap = 8'h3c;
      src = 63'h1;
      see(1'b1, 1'b1, 2, alt);
      @(negedge i_clk);
      trap = 8'hc1;
      see(1'b1, 1'b0, 8, alt);
      @(negedge i_clk);
      trap = 8'h00;
      $display("trap test done");
   endtask
   task automatic t_groups;
      for (int i = 0; i < 63; i++) begin
         @(negedge i_clk);
         src = 63'h1 << i;
         alt = i[0];
         see(1'b1, 1'b0, rq[i] + 8, alt);
      end
      $display("source map test done");
   endtask
   task automatic t_arb;
      @(negedge i_clk);
      src = (63'h1 << 53) | 63'h1;
      see(1'b1, 1'b0, 8, alt);
      @(negedge i_clk);
      pri[215:213] = 3'h2;
      see(1'b1, 1'b0, 79, alt);
      @(negedge i_clk);
      lvl = 3'h1;
      see(1'b1, 1'b0, 79, alt);
      @(negedge i_clk);
      lvl = 3'h2;
      see(1'b0, 1'b0, 0, alt);
      @(negedge i_clk);
      lvl = 3'h0;
      en[71] = 1'b0;
      see(1'b1, 1'b0, 8, alt);
      @(negedge i_clk);
      pri[2:0] = 3'h0;
      see(1'b0, 1'b0, 0, alt);
      @(negedge i_clk);
      pri = {72{3'h1}};
      en = '1;
      $display("arbitration test done");
   endtask
   task automatic t_take(input logic [3:0] w);
      logic [23:0] last;
      wt = w;
      for (int k = 0; k < 63; k += 53) begin
         @(negedge i_clk);
         src = 63'h1 << k;
         alt = w[0];
         go = 1'b1;
         @(posedge i_clk);
         for (int c = 0; c < 30 && ack !== 1'b1; c++) @(posedge i_clk);
         #1;
         chk(faddr, ea(rq[k] + 8, alt));
         chk(24'(from_rst), 24'h0);
      end
      @(negedge i_clk);
      last = faddr;
      src = '0;
      stray = 1'b1;
      repeat (3 + w) @(negedge i_clk);
      chk(faddr, last);
      stray = 1'b0;
      go = 1'b0;
      $display("vector take test done");
   endtask
   initial begin
      t_reset();
      t_traps();
      t_groups();
      t_arb();
      t_take(4'h0);
      t_take(4'h3);
      t_reset();
      test_done();
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      error_cnt++;
      test_done();
   end
endmodule

// ===== tb/vtm_core_model.sv
// vtm_core_model: behavioural core that takes presented vectors after a set wait
module vtm_core_model (
   input  wire logic       i_clk,
   input  wire logic       i_go,
   input  wire logic       i_stray,
   input  wire logic [3:0] i_wait,
   input  wire logic       i_vec_valid,
   output logic            o_vec_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_ff = 4'h0;
   initial o_vec_ack = 1'b0;
   // ====================
   // wait count
   // stray mode acks with nothing presented, which the block must ignore
   always @(posedge i_clk) begin
      if (o_vec_ack || !(i_go && (i_vec_valid || i_stray))) cnt_ff <= 4'h0;
      else if (cnt_ff != 4'hf) cnt_ff <= cnt_ff + 4'h1;
   end
   // ack moves only off the sampling edge and stays up for one cycle, taken or not
   // fetched entries are trusted; unused ones holding a reset handler is up to software
   always @(negedge i_clk) o_vec_ack <= i_go && (cnt_ff > i_wait);
endmodule
